// *** verilog/emsm_pkg.sv ***
`default_nettype none
package emsm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned ALL_ON_MS = 500;
  localparam int unsigned BLINK_HALF_CYC = (BLINK_HALF_MS * (CLK_HZ / 1000));
  localparam int unsigned ALL_ON_CYC = (ALL_ON_MS * (CLK_HZ / 1000));

  // ----------------------------------------------------------------
  // Holding register protocol addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RUN_HOURS_HI = 16'h9C41;
  localparam logic [15:0] ADDR_RUN_HOURS_LO = 16'h9C42;
  localparam logic [15:0] ADDR_SPEED_RPM = 16'h9C43;
  localparam logic [15:0] ADDR_SUPPLY_TENTHS = 16'h9C44;
  localparam logic [15:0] ADDR_OIL_KPA = 16'h9C45;
  localparam logic [15:0] ADDR_TEMP_C = 16'h9C46;
  localparam logic [15:0] ADDR_STATE_CODE = 16'h9C47;
  localparam logic [15:0] ADDR_SHUTDOWN_A = 16'h9C48;
  localparam logic [15:0] ADDR_LIVE_SETPOINT = 16'h9C50;
  localparam logic [15:0] ADDR_COMMIT = 16'h9D30;

  localparam logic [15:0] COMMIT_VALUE = 16'h0001;
  localparam logic [7:0] NODE_DEFAULT = 8'h01;
  localparam logic [7:0] NODE_BROADCAST = 8'h00;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;

  // ----------------------------------------------------------------
  // Shutdown word layout
  // ----------------------------------------------------------------
  localparam int unsigned SD_FAULT_BITS = 12;
  localparam logic [15:0] SD_USED_MASK = 16'h0FFF;
  localparam int unsigned SD_OVERSPEED = 0;
  localparam int unsigned SD_FILTER_RESTRICT = 11;

  // ----------------------------------------------------------------
  // Security levels and controller state codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEC_HIGH = 2'h3;

  typedef enum logic [4:0] {
    EMSM_ST_ECU_STABILIZE, EMSM_ST_STOPPED, EMSM_ST_STANDBY, EMSM_ST_PRESTART1,
    EMSM_ST_SAFE_CHECK, EMSM_ST_PRESTART2, EMSM_ST_CRANKING, EMSM_ST_CRANK_REST,
    EMSM_ST_FALSE_START, EMSM_ST_WARMUP, EMSM_ST_LINE_FILL1, EMSM_ST_LINE_FILL2,
    EMSM_ST_RUN_LOADED, EMSM_ST_COOLDOWN, EMSM_ST_ETS_WAIT, EMSM_ST_SPINDOWN,
    EMSM_ST_WAIT_START
  } emsm_state_code_t;

  typedef enum logic [2:0] {
    EMSM_LD_IDLE, EMSM_LD_ALL_ON, EMSM_LD_FLASHING, EMSM_LD_DONE, EMSM_LD_BOOT
  } emsm_load_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] node;
    logic [15:0] addr;
    logic [15:0] wdata;
  } emsm_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [15:0] rdata;
  } emsm_resp_t;

  typedef struct packed {
    logic red;
    logic amber;
    logic green;
  } emsm_leds_t;

endpackage
`default_nettype wire

// *** verilog/emsm_status_map.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Run hours are one 32-bit read-only value over two adjacent registers.
// - Speed, oil pressure and temperature each read from their own read-only register.
// - Supply voltage reads back as tenths of a volt, read-only.
// - Controller state reads as one numeric code; one state at a time.
// - Codes 0 to 8 cover stabilize wait through false-start check.
// - Codes 9 to 16 cover warmup wait through wait-to-start.
// - Shutdown word bit is one while its fault is active.
// - Bits 0 to 4: overspeed, underspeed, overcrank, low oil, high temperature.
// - Bits 5 to 11: fuel, discharge, speed loss, lube, leak, filter faults.
// - Bus writes are temporary; after power cycle the panel value returns.
// - Writing one to the commit register makes the device save changes.
// - High security panel user sees three passcodes but cannot change them.
// - File list shows only own-hardware files with the configuration extension.
// - Loading blanks screen, lights all LEDs, flashes amber; done shows green, flashes others.
// - After a good load, drive removal or power cycle restarts the controller.
// - Failed load stays in bootloader until a full file loads.
// - Registers answer as a bus slave at a node address defaulting to one.
module emsm_status_map
  import emsm_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
  parameter int unsigned ALL_ON = ALL_ON_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Register request from the serial framer
  input wire emsm_req_t req_in,
  input wire logic [7:0] node_addr_in,
  output emsm_resp_t resp_out,
  // Engine measurements
  input wire logic [31:0] run_hours_in,
  input wire logic [15:0] speed_rpm_in,
  input wire logic [15:0] supply_tenths_in,
  input wire logic [15:0] oil_kpa_in,
  input wire logic [15:0] temp_c_in,
  input wire emsm_state_code_t state_code_in,
  input wire logic [SD_FAULT_BITS-1:0] faults_in,
  // Setting held by the panel and its save path
  input wire logic [15:0] panel_setpoint_in,
  output logic [15:0] live_setpoint_out,
  output logic save_pulse_out,
  output logic [15:0] save_value_out,
  // Panel passcode view
  input wire logic [1:0] sec_level_in,
  input wire logic view_codes_in,
  input wire logic [15:0] code_low_in,
  input wire logic [15:0] code_med_in,
  input wire logic [15:0] code_high_in,
  output logic [47:0] codes_view_out,
  // Configuration load from removable drive
  input wire logic usb_present_in,
  input wire logic file_hw_match_in,
  input wire logic file_ext_match_in,
  input wire logic file_is_full_in,
  input wire logic load_start_in,
  input wire logic load_done_in,
  input wire logic load_fail_in,
  input wire logic boot_pending_nv_in,
  output logic file_listed_out,
  output logic display_blank_out,
  output emsm_leds_t leds_out,
  output logic boot_pending_set_out,
  output logic restart_out
);

  if (BLINK_HALF < 1 || ALL_ON < 1) begin : g_bad_counts
    $error("Blink and all-on counts must be at least one");
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic addressed;
  logic broadcast;
  logic take_rd;
  logic take_wr;
  assign broadcast = (req_in.node == NODE_BROADCAST);
  assign addressed = (req_in.node == node_addr_in) || broadcast;
  assign take_rd = req_in.rd && (req_in.node == node_addr_in);
  assign take_wr = req_in.wr && addressed;

  logic [15:0] shutdown_word;
  assign shutdown_word = {4'h0, faults_in} & SD_USED_MASK;
  logic override_r;
  logic [15:0] bus_setpoint_r;
  assign live_setpoint_out = override_r ? bus_setpoint_r : panel_setpoint_in;

  logic [15:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 16'h0000;
    case (req_in.addr)
      ADDR_RUN_HOURS_HI: rd_word = run_hours_in[31:16];
      ADDR_RUN_HOURS_LO: rd_word = run_hours_in[15:0];
      ADDR_SPEED_RPM: rd_word = speed_rpm_in;
      ADDR_SUPPLY_TENTHS: rd_word = supply_tenths_in;
      ADDR_OIL_KPA: rd_word = oil_kpa_in;
      ADDR_TEMP_C: rd_word = temp_c_in;
      ADDR_STATE_CODE: rd_word = {11'h000, state_code_in};
      ADDR_SHUTDOWN_A: rd_word = shutdown_word;
      ADDR_LIVE_SETPOINT: rd_word = live_setpoint_out;
      ADDR_COMMIT: rd_word = 16'h0000;
      default: rd_hit = 1'b0;
    endcase
  end

  // Only the setpoint and commit take writes; everything else is read-only
  logic wr_ok;
  assign wr_ok = (req_in.addr == ADDR_LIVE_SETPOINT) || (req_in.addr == ADDR_COMMIT);

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  // Broadcast writes act but get no answer, as on any multidrop slave
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resp_out <= '0;
    end else begin
      resp_out.valid <= take_rd || (take_wr && !broadcast);
      if (take_rd) begin
        resp_out.exc <= rd_hit ? EXC_NONE : EXC_BAD_ADDR;
        resp_out.rdata <= rd_hit ? rd_word : 16'h0000;
      end else if (take_wr) begin
        resp_out.exc <= wr_ok ? EXC_NONE : EXC_BAD_ADDR;
        resp_out.rdata <= req_in.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Temporary setting and commit
  // ----------------------------------------------------------------
  // Reset stands in for power cycling: the override drops, panel value shows again
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      override_r <= 1'b0;
      bus_setpoint_r <= 16'h0000;
    end else if (take_wr && req_in.addr == ADDR_LIVE_SETPOINT) begin
      override_r <= 1'b1;
      bus_setpoint_r <= req_in.wdata;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      save_pulse_out <= 1'b0;
      save_value_out <= 16'h0000;
    end else begin
      save_pulse_out <= take_wr && req_in.addr == ADDR_COMMIT
                        && req_in.wdata == COMMIT_VALUE;
      save_value_out <= live_setpoint_out;
    end
  end

  // ----------------------------------------------------------------
  // Passcode view
  // ----------------------------------------------------------------
  // No path from the panel reaches the codes; they are only mirrored out
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      codes_view_out <= '0;
    end else if (view_codes_in && sec_level_in == SEC_HIGH) begin
      codes_view_out <= {code_low_in, code_med_in, code_high_in};
    end else begin
      codes_view_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Drive presence and boot flag synchronisers
  // ----------------------------------------------------------------
  logic usb_s1_r;
  logic usb_s2_r;
  logic nv_s1_r;
  logic nv_s2_r;
  logic nv_seen_r;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      usb_s1_r <= 1'b0;
      usb_s2_r <= 1'b0;
      nv_s1_r <= 1'b0;
      nv_s2_r <= 1'b0;
    end else begin
      usb_s1_r <= usb_present_in;
      usb_s2_r <= usb_s1_r;
      nv_s1_r <= boot_pending_nv_in;
      nv_s2_r <= nv_s1_r;
    end
  end

  // Boot flag is read every idle cycle from when it has crossed the synchroniser after release
  logic [1:0] nv_wait_r;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_wait_r <= 2'h0;
      nv_seen_r <= 1'b0;
    end else if (nv_wait_r != 2'h2) begin
      nv_wait_r <= nv_wait_r + 2'h1;
    end else begin
      nv_seen_r <= 1'b1;
    end
  end

  assign file_listed_out = usb_s2_r && file_hw_match_in && file_ext_match_in;
  // ----------------------------------------------------------------
  // Blink divider
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt_r;
  logic blink_r;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == BLINK_HALF - 1) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= !blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Configuration load sequencer
  // ----------------------------------------------------------------
  emsm_load_t ld_r;
  emsm_load_t ld_nxt;
  logic [31:0] all_cnt_r;
  logic start_ok;
  assign start_ok = load_start_in && file_listed_out;

  always_comb begin
    ld_nxt = ld_r;
    case (ld_r)
      EMSM_LD_IDLE: begin
        if (nv_seen_r && nv_s2_r) begin
          ld_nxt = EMSM_LD_BOOT;
        end else if (start_ok && nv_seen_r) begin
          ld_nxt = EMSM_LD_ALL_ON;
        end
      end
      EMSM_LD_ALL_ON: begin
        if (load_fail_in || !usb_s2_r) begin
          ld_nxt = EMSM_LD_BOOT;
        end else if (all_cnt_r == ALL_ON - 1) begin
          ld_nxt = EMSM_LD_FLASHING;
        end
      end
      EMSM_LD_FLASHING: begin
        if (load_fail_in || !usb_s2_r) begin
          ld_nxt = EMSM_LD_BOOT;
        end else if (load_done_in) begin
          ld_nxt = EMSM_LD_DONE;
        end
      end
      EMSM_LD_DONE: ld_nxt = EMSM_LD_DONE;
      EMSM_LD_BOOT: begin
        // Only a complete full file gets out of the bootloader
        if (start_ok && file_is_full_in) begin
          ld_nxt = EMSM_LD_ALL_ON;
        end
      end
      default: ld_nxt = EMSM_LD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ld_r <= EMSM_LD_IDLE;
      all_cnt_r <= 32'h0000_0000;
    end else begin
      ld_r <= ld_nxt;
      if (ld_r == EMSM_LD_ALL_ON && ld_nxt == EMSM_LD_ALL_ON) begin
        all_cnt_r <= all_cnt_r + 32'h0000_0001;
      end else begin
        all_cnt_r <= 32'h0000_0000;
      end
    end
  end

  // Flag survives power loss outside; set on failure, cleared by a good load
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_pending_set_out <= 1'b0;
    end else if (ld_nxt == EMSM_LD_BOOT) begin
      boot_pending_set_out <= 1'b1;
    end else if (ld_nxt == EMSM_LD_DONE) begin
      boot_pending_set_out <= 1'b0;
    end else if (ld_r == EMSM_LD_IDLE && nv_seen_r) begin
      boot_pending_set_out <= nv_s2_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      display_blank_out <= 1'b0;
      leds_out <= '0;
      restart_out <= 1'b0;
    end else begin
      display_blank_out <= (ld_nxt != EMSM_LD_IDLE);
      restart_out <= (ld_r == EMSM_LD_DONE) && !usb_s2_r;
      case (ld_nxt)
        EMSM_LD_ALL_ON: leds_out <= '{red: 1'b1, amber: 1'b1, green: 1'b1};
        EMSM_LD_FLASHING: leds_out <= '{red: 1'b0, amber: blink_r, green: 1'b0};
        EMSM_LD_DONE: leds_out <= '{red: blink_r, amber: blink_r, green: 1'b1};
        EMSM_LD_BOOT: leds_out <= '{red: 1'b0, amber: blink_r, green: 1'b0};
        default: leds_out <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_commit_req;
    take_wr && req_in.addr == ADDR_COMMIT && req_in.wdata == COMMIT_VALUE;
  endsequence
  sequence s_setpoint_wr;
    take_wr && req_in.addr == ADDR_LIVE_SETPOINT;
  endsequence

  AST_HOURS_HI: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take_rd && req_in.addr == ADDR_RUN_HOURS_HI |=> resp_out.rdata == $past(run_hours_in[31:16]))
    else $error("Run hours high word mismatch");
  AST_SUPPLY: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take_rd && req_in.addr == ADDR_SUPPLY_TENTHS |=> resp_out.valid
      && resp_out.rdata == $past(supply_tenths_in))
    else $error("Supply voltage readback wrong");
  AST_STATE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take_rd && req_in.addr == ADDR_STATE_CODE |=> resp_out.rdata[15:5] == 11'h000
      && resp_out.rdata[4:0] == $past(state_code_in))
    else $error("State code readback wrong");
  AST_SD_RESERVED: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take_rd && req_in.addr == ADDR_SHUTDOWN_A |=> resp_out.rdata[15:12] == 4'h0
      && resp_out.rdata[SD_FILTER_RESTRICT:SD_OVERSPEED] == $past(faults_in))
    else $error("Shutdown word bits wrong");
  AST_RO_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take_wr && !broadcast && req_in.addr == ADDR_SHUTDOWN_A |=> resp_out.exc == EXC_BAD_ADDR)
    else $error("Write to read-only register accepted");
  AST_SETPOINT_WR: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    s_setpoint_wr |=> live_setpoint_out == $past(req_in.wdata) ##1 override_r)
    else $error("Bus setpoint not applied");
  AST_COMMIT: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    s_commit_req |=> save_pulse_out && save_value_out == $past(live_setpoint_out)
      ##1 !save_pulse_out || $past(take_wr, 1))
    else $error("Commit did not save");
  AST_NO_SAVE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !(take_wr && req_in.addr == ADDR_COMMIT) |=> !save_pulse_out)
    else $error("Save without commit");
  AST_CODES: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    sec_level_in != SEC_HIGH |=> codes_view_out == 48'h0000_0000_0000)
    else $error("Passcodes shown below high security");
  AST_DONE_LEDS: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ld_r == EMSM_LD_DONE |-> leds_out.green && leds_out.red == leds_out.amber)
    else $error("Completion indication wrong");
  AST_BOOT_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ld_r == EMSM_LD_BOOT && !(start_ok && file_is_full_in) |=> ld_r == EMSM_LD_BOOT)
    else $error("Bootloader left without full file");
  AST_RESTART: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ld_r == EMSM_LD_DONE && !usb_s2_r |=> restart_out)
    else $error("No restart after drive removal");

endmodule
`default_nettype wire

// *** testbench/emsm_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module emsm_master_model
  import emsm_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Request and answer
  output emsm_req_t req_out,
  input wire emsm_resp_t resp_in
);
  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  initial req_out = '0;

  // One-cycle request; the answer is looked for in the next three cycles
  task automatic xfer(input logic rd, input logic wr, input logic [7:0] node,
                      input logic [15:0] addr, input logic [15:0] wdata,
                      output emsm_resp_t resp, output int lat);
    @(posedge ref_clk_in);
    req_out <= '{rd: rd, wr: wr, node: node, addr: addr, wdata: wdata};
    @(posedge ref_clk_in);
    req_out.rd <= 1'b0;
    req_out.wr <= 1'b0;
    // Stale address would hide a design that keeps sampling after release
    req_out.addr <= ~addr;
    lat = 0;
    resp = '0;
    for (int i = 1; i <= 3; i++) begin
      @(negedge ref_clk_in);
      if (resp_in.valid === 1'b1 && lat == 0) begin
        lat = i;
        resp = resp_in;
      end
    end
  endtask

  // Save request always carries the value one
  task automatic commit(input logic [7:0] node, output emsm_resp_t resp, output int lat);
    xfer(1'b0, 1'b1, node, ADDR_COMMIT, COMMIT_VALUE, resp, lat);
  endtask
endmodule
`default_nettype wire

// *** testbench/emsm_status_map_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module emsm_status_map_test;
  import emsm_pkg::*;
  localparam int unsigned BH = 4;
  localparam int unsigned AO = 6;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] node = NODE_DEFAULT;
  logic [31:0] hours = '0;
  logic [15:0] spd = '0, sup = '0, oil = '0, tmp = '0, psp = '0, cl = '0, cm = '0, ch = '0;
  emsm_state_code_t st = EMSM_ST_ECU_STABILIZE;
  logic [11:0] flt = '0;
  logic [1:0] sec = '0;
  logic view = 0, usb = 0, hw = 0, ext = 0, full = 0, start = 0, done = 0, fail = 0;
  logic nv = 1'b0;
  emsm_req_t req;
  emsm_resp_t resp;
  emsm_leds_t leds;
  logic [15:0] live_sp, save_v;
  logic [47:0] codes;
  logic save_p, listed, blank, boot_set, restart;
  int mismatches = 0, comparisons = 0, saves = 0;
  logic [15:0] last_save = '0;

  always #10 ref_clk = ~ref_clk;

  emsm_master_model u_master (.ref_clk_in(ref_clk), .req_out(req), .resp_in(resp));

  emsm_status_map #(.BLINK_HALF(BH), .ALL_ON(AO)) u_dut (
    .ref_clk_in(ref_clk), .rst_b_in(rst_b), .req_in(req), .node_addr_in(node),
    .resp_out(resp), .run_hours_in(hours), .speed_rpm_in(spd), .supply_tenths_in(sup),
    .oil_kpa_in(oil), .temp_c_in(tmp), .state_code_in(st), .faults_in(flt),
    .panel_setpoint_in(psp), .live_setpoint_out(live_sp), .save_pulse_out(save_p),
    .save_value_out(save_v), .sec_level_in(sec), .view_codes_in(view), .code_low_in(cl),
    .code_med_in(cm), .code_high_in(ch), .codes_view_out(codes), .usb_present_in(usb),
    .file_hw_match_in(hw), .file_ext_match_in(ext), .file_is_full_in(full),
    .load_start_in(start), .load_done_in(done), .load_fail_in(fail),
    .boot_pending_nv_in(nv), .file_listed_out(listed), .display_blank_out(blank),
    .leds_out(leds), .boot_pending_set_out(boot_set), .restart_out(restart));

  // Save pulses stand one cycle, so they are caught mid-cycle
  always @(negedge ref_clk) begin
    if (save_p === 1'b1) begin
      saves++;
      last_save = save_v;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic rd, input logic [7:0] nd, input logic [15:0] a,
                     input logic [15:0] wd, input int lat_e, input logic [7:0] exc,
                     input logic [15:0] exp);
    emsm_resp_t r;
    int lat;
    u_master.xfer(rd, ~rd, nd, a, wd, r, lat);
    chk(48'(lat), 48'(lat_e), "answer latency");
    if (lat_e != 0) chk({r.exc, r.rdata}, {exc, exp}, "answer");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    cyc(5);
  endtask

  // Amber toggles counted; green and red judged every cycle
  task automatic blink(input logic grn, input logic pair, output int tog, output int bad);
    logic a;
    tog = 0;
    bad = 0;
    a = leds.amber;
    repeat (20) begin
      @(negedge ref_clk);
      if (leds.amber !== a) tog++;
      a = leds.amber;
      if (leds.green !== grn || leds.red !== (pair ? leds.amber : 1'b0)) bad++;
    end
    // Hand back on a rising edge so the next stimulus lands there
    @(posedge ref_clk);
  endtask

  task automatic pulse(ref logic s);
    s <= 1'b1;
    cyc(1);
    s <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_meas();
    hours <= 32'h1234ABCD;
    spd <= 16'h0ABC;
    sup <= 16'h007D;
    oil <= 16'h01F4;
    tmp <= 16'h0058;
    acc(1, NODE_DEFAULT, ADDR_RUN_HOURS_HI, 0, 1, EXC_NONE, 16'h1234);
    acc(1, NODE_DEFAULT, ADDR_RUN_HOURS_LO, 0, 1, EXC_NONE, 16'hABCD);
    acc(1, NODE_DEFAULT, ADDR_SPEED_RPM, 0, 1, EXC_NONE, 16'h0ABC);
    acc(1, NODE_DEFAULT, ADDR_OIL_KPA, 0, 1, EXC_NONE, 16'h01F4);
    acc(1, NODE_DEFAULT, ADDR_TEMP_C, 0, 1, EXC_NONE, 16'h0058);
    acc(1, NODE_DEFAULT, ADDR_SUPPLY_TENTHS, 0, 1, EXC_NONE, 16'h007D);
    acc(0, NODE_DEFAULT, ADDR_SPEED_RPM, 16'h0001, 1, EXC_BAD_ADDR, 16'h0001);
    acc(1, NODE_DEFAULT, ADDR_SPEED_RPM, 0, 1, EXC_NONE, 16'h0ABC);
    acc(1, NODE_DEFAULT, 16'h9C49, 0, 1, EXC_BAD_ADDR, 16'h0000);
    for (int i = 0; i <= 16; i++) begin
      st <= emsm_state_code_t'(i);
      acc(1, NODE_DEFAULT, ADDR_STATE_CODE, 0, 1, EXC_NONE, 16'(i));
    end
    for (int i = 0; i < 12; i++) begin
      flt <= 12'h001 << i;
      acc(1, NODE_DEFAULT, ADDR_SHUTDOWN_A, 0, 1, EXC_NONE, 16'h0001 << i);
    end
    flt <= 12'hFFF;
    acc(1, NODE_DEFAULT, ADDR_SHUTDOWN_A, 0, 1, EXC_NONE, 16'h0FFF);
    acc(0, NODE_DEFAULT, ADDR_SHUTDOWN_A, 16'hF000, 1, EXC_BAD_ADDR, 16'hF000);
    acc(1, NODE_DEFAULT, ADDR_SHUTDOWN_A, 0, 1, EXC_NONE, 16'h0FFF);
  endtask

  task automatic t_setpoint();
    emsm_resp_t r;
    int lat;
    psp <= 16'h0123;
    acc(1, NODE_DEFAULT, ADDR_LIVE_SETPOINT, 0, 1, EXC_NONE, 16'h0123);
    acc(0, NODE_DEFAULT, ADDR_LIVE_SETPOINT, 16'h0456, 1, EXC_NONE, 16'h0456);
    chk(live_sp, 16'h0456, "live value");
    acc(0, NODE_DEFAULT, ADDR_COMMIT, 16'h0002, 1, EXC_NONE, 16'h0002);
    chk(48'(saves), 0, "save count");
    u_master.commit(NODE_DEFAULT, r, lat);
    chk(48'(saves), 1, "save count");
    chk(last_save, 16'h0456, "saved value");
    do_reset();
    chk(live_sp, 16'h0123, "panel value back");
  endtask

  task automatic t_node();
    node <= 8'h05;
    acc(1, NODE_DEFAULT, ADDR_SPEED_RPM, 0, 0, EXC_NONE, 0);
    acc(1, 8'h05, ADDR_SPEED_RPM, 0, 1, EXC_NONE, 16'h0ABC);
    acc(0, NODE_BROADCAST, ADDR_LIVE_SETPOINT, 16'h0777, 0, EXC_NONE, 0);
    chk(live_sp, 16'h0777, "broadcast write");
    node <= NODE_DEFAULT;
  endtask

  task automatic t_codes();
    cl <= 16'h1111;
    cm <= 16'h2222;
    ch <= 16'h3333;
    sec <= SEC_HIGH;
    view <= 1'b1;
    cyc(3);
    chk(codes, 48'h111122223333, "code view");
    sec <= 2'h2;
    cyc(3);
    chk(codes, 0, "code view hidden");
  endtask

  task automatic t_load();
    int tog, bad;
    usb <= 1'b1;
    hw <= 1'b1;
    ext <= 1'b0;
    cyc(4);
    chk(listed, 0, "listed wrong extension");
    pulse(start);
    cyc(2);
    chk({blank, leds}, 0, "start with no file");
    hw <= 1'b0;
    ext <= 1'b1;
    cyc(1);
    chk(listed, 0, "listed wrong hardware");
    hw <= 1'b1;
    cyc(1);
    chk(listed, 1, "listed");
    pulse(start);
    @(negedge ref_clk);
    chk({blank, leds}, 4'hF, "all on");
    cyc(AO + 1);
    blink(1'b0, 1'b0, tog, bad);
    chk(48'(tog >= 4), 1, "amber flashing");
    chk(48'(bad), 0, "others dark");
    pulse(done);
    cyc(2);
    blink(1'b1, 1'b1, tog, bad);
    chk(48'(tog >= 4), 1, "done flashing");
    chk(48'(bad), 0, "green steady");
    chk(restart, 0, "no restart with drive");
    usb <= 1'b0;
    cyc(5);
    chk(restart, 1, "restart on removal");
    do_reset();
  endtask

  task automatic t_boot();
    int tog, bad;
    usb <= 1'b1;
    full <= 1'b0;
    cyc(4);
    pulse(start);
    cyc(3);
    pulse(fail);
    cyc(3);
    chk(boot_set, 1, "boot flag");
    blink(1'b0, 1'b0, tog, bad);
    chk(48'(tog >= 4), 1, "boot flashing");
    pulse(start);
    cyc(3);
    chk({boot_set, leds.green}, 2'b10, "partial file refused");
    // The stored boot flag survives a power cycle and brings the bootloader back
    nv <= 1'b1;
    do_reset();
    cyc(2);
    chk({boot_set, blank, leds.green}, 3'b110, "boot after power cycle");
    full <= 1'b1;
    pulse(start);
    @(negedge ref_clk);
    chk(leds, 3'b111, "full file accepted");
  endtask

  initial begin
    cyc(16);
    rst_b <= 1'b1;
    cyc(5);
    t_meas();
    t_setpoint();
    t_node();
    t_codes();
    t_load();
    t_boot();
    final_report();
  end

  initial begin
    cyc(8000);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
